// ===== flash_guard_pkg.sv
package flash_guard_pkg;

   // program store control register
   localparam logic [7:0]  CTRL_SFR_ADDR     = 8'h8f;
   localparam logic [7:0]  CTRL_RESET        = 8'h00;
   localparam int          WRITE_ALLOW_BIT   = 0;
   localparam int          ERASE_ALLOW_BIT   = 1;
   localparam logic [7:0]  READ_ZERO         = 8'h00;

   // flash map
   localparam logic [15:0] SCRATCH_BASE      = 16'h8000;
   localparam logic [15:0] SCRATCH_LAST      = 16'h807f;
   localparam int          FLASH_BYTES       = 32896;
   localparam logic [15:0] MAIN_SECTOR_MASK  = 16'hfe00;
   localparam logic [15:0] MAIN_SECTOR_SPAN  = 16'h01ff;
   localparam logic [15:0] SCRATCH_SPAN      = 16'h007f;
   localparam int          MAIN_SECTOR_BYTES = 512;
   localparam logic [15:0] LOCK_SECTOR_BASE  = 16'h7c00;
   localparam logic [15:0] READ_LOCK_ADDR    = 16'h7dff;
   localparam logic [15:0] WE_LOCK_ADDR      = 16'h7dfe;
   localparam int          BLOCK_SHIFT       = 12;
   localparam logic [7:0]  ERASED_BYTE       = 8'hff;
   localparam logic [3:0]  PRESCALE_OFF      = 4'hf;

   // timing
   localparam int          CLOCK_MHZ         = 200;
   localparam int          ERASE_TIME_MS     = 10;
   localparam int          WRITE_TIME_US     = 40;
   localparam int          ERASE_CYCLES_DOC  = ERASE_TIME_MS * 1000 * CLOCK_MHZ;
   localparam int          WRITE_CYCLES_DOC  = WRITE_TIME_US * CLOCK_MHZ;
   localparam int          TIMER_W           = 32;

   // debug port command
   typedef enum logic [1:0] {
      JTAG_READ,
      JTAG_WRITE,
      JTAG_ERASE
   } jtag_cmd_t;

endpackage : flash_guard_pkg

// ===== op_timer_if.sv
`timescale 1ns/1ps
// start and finish of one hardware-timed flash operation
interface op_timer_if;
   logic                                  start;
   logic [flash_guard_pkg::TIMER_W-1:0]   cycles;
   logic                                  done;

   modport ctl (output start, output cycles, input done);
   modport tmr (input start, input cycles, output done);
endinterface : op_timer_if

// ===== op_timer.sv
`timescale 1ns/1ps
module op_timer (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // operation handshake
   op_timer_if.tmr   tif
);

   logic                                  busy_reg;
   logic                                  busy_next;
   logic [flash_guard_pkg::TIMER_W-1:0]   cnt_reg;
   logic [flash_guard_pkg::TIMER_W-1:0]   cnt_next;

   // done pulses in the last cycle of the timed interval
   assign tif.done = busy_reg && (cnt_reg == '0);

   // down counter loaded with cycles minus one
   always_comb begin
      busy_next = busy_reg;
      cnt_next  = cnt_reg;
      if (tif.start) begin
         busy_next = 1'b1;
         cnt_next  = tif.cycles - 1'b1;
      end else if (busy_reg) begin
         if (cnt_reg == '0) begin
            busy_next = 1'b0;
         end else begin
            cnt_next = cnt_reg - 1'b1;
         end
      end
   end

   // state registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
         cnt_reg  <= '0;
      end else begin
         busy_reg <= busy_next;
         cnt_reg  <= cnt_next;
      end
   end

endmodule : op_timer

// ===== flash_write_erase_guard.sv
`timescale 1ns/1ps
module flash_write_erase_guard #(
   parameter int ERASE_CYCLES = flash_guard_pkg::ERASE_CYCLES_DOC,
   parameter int WRITE_CYCLES = flash_guard_pkg::WRITE_CYCLES_DOC
) (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   // special function register port
   input  wire logic [7:0]                 sfr_addr,
   input  wire logic                       sfr_wr,
   input  wire logic                       sfr_rd,
   input  wire logic [7:0]                 sfr_wdata,
   output logic      [7:0]                 sfr_rdata,
   // timing prescale field from the scaler register
   input  wire logic [3:0]                 timing_prescale_field,
   // core xdata move writes and code reads
   input  wire logic                       xdata_move_op,
   input  wire logic [15:0]                xdata_addr,
   input  wire logic [7:0]                 xdata_wdata,
   input  wire logic                       code_read_op,
   input  wire logic [15:0]                code_addr,
   output logic      [7:0]                 code_rdata,
   output logic                            core_stall,
   // debug port flash commands
   input  wire logic                       jtag_req,
   input  wire flash_guard_pkg::jtag_cmd_t jtag_cmd,
   input  wire logic [15:0]                jtag_addr,
   input  wire logic [7:0]                 jtag_wdata,
   output logic      [7:0]                 jtag_rdata,
   output logic                            jtag_ack,
   output logic                            jtag_refused
);

   if (ERASE_CYCLES < flash_guard_pkg::MAIN_SECTOR_BYTES) begin : g_erase_chk
      $error("ERASE_CYCLES must cover one cycle per sector byte");
   end
   if (WRITE_CYCLES < 1) begin : g_write_chk
      $error("WRITE_CYCLES must be at least one");
   end

   typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_ERASE} op_state_t;

   logic [7:0]   flash_mem [0:flash_guard_pkg::FLASH_BYTES-1];
   op_timer_if   tif ();

   op_state_t    state_reg, state_next;
   logic [1:0]   ctrl_reg, ctrl_next;
   logic [7:0]   sfr_rdata_reg, sfr_rdata_next;
   logic [7:0]   code_rdata_reg, code_rdata_next;
   logic [7:0]   jtag_rdata_reg, jtag_rdata_next;
   logic         stall_reg, stall_next;
   logic         ack_reg, ack_next;
   logic         refused_reg, refused_next;
   logic         from_jtag_reg, from_jtag_next;
   logic [15:0]  ptr_reg, ptr_next;
   logic [15:0]  last_reg, last_next;
   logic         walk_done_reg, walk_done_next;
   logic         mem_we;
   logic [15:0]  mem_waddr;
   logic [7:0]   mem_wdata;

   logic         prescale_ok;
   logic         x_in_flash, j_in_flash;
   logic [15:0]  x_base, x_last, j_base, j_last;
   logic [2:0]   j_block;
   logic         j_read_ok, j_mod_ok;

   // fresh part ships fully erased
   initial begin
      for (int i = 0; i < flash_guard_pkg::FLASH_BYTES; i++) begin
         flash_mem[i] = flash_guard_pkg::ERASED_BYTE;
      end
   end

   // sector bounds: 512-byte main sectors, one 128-byte scratch sector
   always_comb begin
      x_in_flash = xdata_addr <= flash_guard_pkg::SCRATCH_LAST;
      j_in_flash = jtag_addr <= flash_guard_pkg::SCRATCH_LAST;
      if (xdata_addr >= flash_guard_pkg::SCRATCH_BASE) begin
         x_base = flash_guard_pkg::SCRATCH_BASE;
         x_last = flash_guard_pkg::SCRATCH_BASE | flash_guard_pkg::SCRATCH_SPAN;
      end else begin
         x_base = xdata_addr & flash_guard_pkg::MAIN_SECTOR_MASK;
         x_last = x_base | flash_guard_pkg::MAIN_SECTOR_SPAN;
      end
      if (jtag_addr >= flash_guard_pkg::SCRATCH_BASE) begin
         j_base = flash_guard_pkg::SCRATCH_BASE;
         j_last = flash_guard_pkg::SCRATCH_BASE | flash_guard_pkg::SCRATCH_SPAN;
      end else begin
         j_base = jtag_addr & flash_guard_pkg::MAIN_SECTOR_MASK;
         j_last = j_base | flash_guard_pkg::MAIN_SECTOR_SPAN;
      end
   end

   // lock bits: one bit per 4 kbyte block, scratch sector is unlocked
   always_comb begin
      j_block   = jtag_addr[flash_guard_pkg::BLOCK_SHIFT +: 3];
      j_read_ok = (jtag_addr >= flash_guard_pkg::SCRATCH_BASE) ||
                  flash_mem[flash_guard_pkg::READ_LOCK_ADDR][j_block];
      j_mod_ok  = (jtag_addr >= flash_guard_pkg::SCRATCH_BASE) ||
                  flash_mem[flash_guard_pkg::WE_LOCK_ADDR][j_block];
      prescale_ok = timing_prescale_field != flash_guard_pkg::PRESCALE_OFF;
   end

   // control register, request decode and operation sequencing
   always_comb begin
      state_next      = state_reg;
      ctrl_next       = ctrl_reg;
      sfr_rdata_next  = flash_guard_pkg::READ_ZERO;
      code_rdata_next = code_rdata_reg;
      jtag_rdata_next = jtag_rdata_reg;
      stall_next      = stall_reg;
      ack_next        = 1'b0;
      refused_next    = 1'b0;
      from_jtag_next  = from_jtag_reg;
      ptr_next        = ptr_reg;
      last_next       = last_reg;
      walk_done_next  = walk_done_reg;
      mem_we          = 1'b0;
      mem_waddr       = xdata_addr;
      mem_wdata       = xdata_wdata;
      tif.start       = 1'b0;
      tif.cycles      = '0;

      if (sfr_wr && sfr_addr == flash_guard_pkg::CTRL_SFR_ADDR) begin
         ctrl_next = sfr_wdata[1:0];
      end
      if (sfr_rd && sfr_addr == flash_guard_pkg::CTRL_SFR_ADDR) begin
         sfr_rdata_next = {6'b00_0000, ctrl_reg};
      end
      if (code_read_op) begin
         code_rdata_next = (code_addr <= flash_guard_pkg::SCRATCH_LAST) ?
                           flash_mem[code_addr] : flash_guard_pkg::READ_ZERO;
      end

      unique case (state_reg)
         OP_IDLE: begin
            if (xdata_move_op && x_in_flash && prescale_ok &&
                ctrl_reg[flash_guard_pkg::WRITE_ALLOW_BIT]) begin
               from_jtag_next = 1'b0;
               if (ctrl_reg[flash_guard_pkg::ERASE_ALLOW_BIT]) begin
                  if (x_base != flash_guard_pkg::LOCK_SECTOR_BASE) begin
                     state_next     = OP_ERASE;
                     stall_next     = 1'b1;
                     ptr_next       = x_base;
                     last_next      = x_last;
                     walk_done_next = 1'b0;
                     tif.start      = 1'b1;
                     tif.cycles     = flash_guard_pkg::TIMER_W'(ERASE_CYCLES);
                  end
               end else begin
                  state_next = OP_WRITE;
                  stall_next = 1'b1;
                  mem_we     = 1'b1;
                  mem_waddr  = xdata_addr;
                  mem_wdata  = flash_mem[xdata_addr] & xdata_wdata;
                  tif.start  = 1'b1;
                  tif.cycles = flash_guard_pkg::TIMER_W'(WRITE_CYCLES);
               end
            end else if (jtag_req) begin
               from_jtag_next = 1'b1;
               unique case (jtag_cmd)
                  flash_guard_pkg::JTAG_READ: begin
                     if (j_in_flash && j_read_ok) begin
                        jtag_rdata_next = flash_mem[jtag_addr];
                        ack_next        = 1'b1;
                     end else begin
                        refused_next = 1'b1;
                     end
                  end
                  flash_guard_pkg::JTAG_WRITE: begin
                     if (j_in_flash && j_mod_ok && prescale_ok) begin
                        state_next = OP_WRITE;
                        mem_we     = 1'b1;
                        mem_waddr  = jtag_addr;
                        mem_wdata  = flash_mem[jtag_addr] & jtag_wdata;
                        tif.start  = 1'b1;
                        tif.cycles = flash_guard_pkg::TIMER_W'(WRITE_CYCLES);
                     end else begin
                        refused_next = 1'b1;
                     end
                  end
                  flash_guard_pkg::JTAG_ERASE: begin
                     if (j_in_flash && j_mod_ok && prescale_ok) begin
                        state_next     = OP_ERASE;
                        ptr_next       = j_base;
                        last_next      = j_last;
                        walk_done_next = 1'b0;
                        tif.start      = 1'b1;
                        tif.cycles     = flash_guard_pkg::TIMER_W'(ERASE_CYCLES);
                     end else begin
                        refused_next = 1'b1;
                     end
                  end
                  default: begin
                     refused_next = 1'b1;
                  end
               endcase
            end
         end
         OP_WRITE, OP_ERASE: begin
            // erase walks the sector one byte per cycle while the timer runs
            if (state_reg == OP_ERASE && !walk_done_reg) begin
               mem_we    = 1'b1;
               mem_waddr = ptr_reg;
               mem_wdata = flash_guard_pkg::ERASED_BYTE;
               ptr_next  = ptr_reg + 16'h0001;
               walk_done_next = ptr_reg == last_reg;
            end
            if (tif.done) begin
               state_next = OP_IDLE;
               stall_next = 1'b0;
               ack_next   = from_jtag_reg;
            end
         end
      endcase
   end

   // flash array write port; a plain clocked process because the array is also preset at time zero
   always @(posedge clock) begin
      if (mem_we) begin
         flash_mem[mem_waddr] <= mem_wdata;
      end
   end

   // state registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg      <= OP_IDLE;
         ctrl_reg       <= flash_guard_pkg::CTRL_RESET[1:0];
         sfr_rdata_reg  <= flash_guard_pkg::READ_ZERO;
         code_rdata_reg <= flash_guard_pkg::READ_ZERO;
         jtag_rdata_reg <= flash_guard_pkg::READ_ZERO;
         stall_reg      <= 1'b0;
         ack_reg        <= 1'b0;
         refused_reg    <= 1'b0;
         from_jtag_reg  <= 1'b0;
         ptr_reg        <= 16'h0000;
         last_reg       <= 16'h0000;
         walk_done_reg  <= 1'b1;
      end else begin
         state_reg      <= state_next;
         ctrl_reg       <= ctrl_next;
         sfr_rdata_reg  <= sfr_rdata_next;
         code_rdata_reg <= code_rdata_next;
         jtag_rdata_reg <= jtag_rdata_next;
         stall_reg      <= stall_next;
         ack_reg        <= ack_next;
         refused_reg    <= refused_next;
         from_jtag_reg  <= from_jtag_next;
         ptr_reg        <= ptr_next;
         last_reg       <= last_next;
         walk_done_reg  <= walk_done_next;
      end
   end

   // operation timer
   op_timer u_timer (
      .clock (clock),
      .rst_n (rst_n),
      .tif   (tif.tmr)
   );

   // outputs straight from flops
   assign sfr_rdata    = sfr_rdata_reg;
   assign code_rdata   = code_rdata_reg;
   assign core_stall   = stall_reg;
   assign jtag_rdata   = jtag_rdata_reg;
   assign jtag_ack     = ack_reg;
   assign jtag_refused = refused_reg;

endmodule : flash_write_erase_guard

// ===== flash_guard_sva.sv
`timescale 1ns/1ps
module flash_guard_sva #(
   parameter int ERASE_CYCLES = 600,
   parameter int WRITE_CYCLES = 4
) (
   // clock, reset and strobes
   input wire logic                       clock, rst_n, sfr_wr, sfr_rd, xdata_move_op,
   input wire logic                       code_read_op, core_stall, jtag_req, jtag_ack,
   input wire logic                       jtag_refused,
   // addresses, data and mode
   input wire logic [7:0]                 sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata,
   input wire logic [7:0]                 code_rdata, jtag_wdata, jtag_rdata,
   input wire logic [15:0]                xdata_addr, code_addr, jtag_addr,
   input wire logic [3:0]                 timing_prescale_field,
   input wire flash_guard_pkg::jtag_cmd_t jtag_cmd
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [1:0] ctrl_reg, ctrl_next;
   logic       jbusy_reg, jbusy_next, idle, wr_ok, ers_ok, take, lock_sec;
   int         run_reg, run_next, exp_reg, exp_next;
   // shadow of the control bits, debug busy and stall length, seen from the ports
   always_comb begin
      idle       = !core_stall && !(jbusy_reg && !jtag_ack && !jtag_refused);
      lock_sec   = xdata_addr >= 16'h7c00 && xdata_addr <= 16'h7dff;
      wr_ok      = idle && xdata_move_op && ctrl_reg[0] && timing_prescale_field != 4'hf
                   && xdata_addr <= 16'h807f;
      ers_ok     = wr_ok && ctrl_reg[1] && !lock_sec;
      take       = ers_ok || (wr_ok && !ctrl_reg[1]);
      ctrl_next  = (sfr_wr && sfr_addr == 8'h8f) ? sfr_wdata[1:0] : ctrl_reg;
      jbusy_next = (jtag_ack || jtag_refused) ? 1'b0 : jbusy_reg;
      if (jtag_req && idle && !take) jbusy_next = 1'b1;
      run_next   = core_stall ? run_reg + 1 : 0;
      exp_next   = take ? (ctrl_reg[1] ? ERASE_CYCLES : WRITE_CYCLES) : exp_reg;
   end
   // helper registers
   always_ff @(posedge clock) begin
      ctrl_reg  <= rst_n ? ctrl_next : 2'b00;
      jbusy_reg <= rst_n ? jbusy_next : 1'b0;
      run_reg   <= rst_n ? run_next : 0;
      exp_reg   <= rst_n ? exp_next : 0;
   end
   chk_ctrl_readback: assert property (
      sfr_rd && sfr_addr == 8'h8f |=> sfr_rdata == {6'h00, $past(ctrl_reg)})
      else $error("control readback wrong");
   chk_unmapped_zero: assert property (
      sfr_rd && sfr_addr != 8'h8f |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   chk_write_timed: assert property (
      take && !ctrl_reg[1] |=> core_stall) else $error("byte write did not stall");
   chk_erase_timed: assert property (
      ers_ok |=> core_stall) else $error("erase did not stall");
   chk_stall_length: assert property (
      $fell(core_stall) |-> run_reg == exp_reg) else $error("stall length wrong");
   chk_no_allow_idle: assert property (
      !core_stall && xdata_move_op && !ctrl_reg[0] |=> !core_stall)
      else $error("stall without allow");
   chk_prescale_core: assert property (
      !core_stall && xdata_move_op && timing_prescale_field == 4'hf |=> !core_stall)
      else $error("core op ran with prescale off");
   chk_lock_no_erase: assert property (
      wr_ok && ctrl_reg[1] && lock_sec |=> !core_stall) else $error("lock sector erased");
   chk_jtag_prescale: assert property (
      jtag_req && idle && !take && jtag_cmd != flash_guard_pkg::JTAG_READ
      && timing_prescale_field == 4'hf |=> jtag_refused && !jtag_ack)
      else $error("debug op ran with prescale off");
   chk_jtag_answer: assert property (
      jtag_req && idle && !take && jtag_cmd == flash_guard_pkg::JTAG_READ
      |=> jtag_ack != jtag_refused)
      else $error("debug read answer wrong");
   chk_code_high_zero: assert property (
      code_read_op && code_addr > 16'h807f |=> code_rdata == 8'h00)
      else $error("high read not zero");
   // main scenarios
   cov_erase: cover property (ers_ok);
   cov_refused: cover property (jtag_refused);
   cov_stall_end: cover property ($fell(core_stall));
endmodule : flash_guard_sva

bind flash_write_erase_guard flash_guard_sva #(.ERASE_CYCLES(ERASE_CYCLES),
   .WRITE_CYCLES(WRITE_CYCLES)) chk (.clock, .rst_n, .sfr_wr, .sfr_rd, .xdata_move_op,
   .code_read_op, .core_stall, .jtag_req, .jtag_ack, .jtag_refused, .sfr_addr, .sfr_wdata,
   .sfr_rdata, .xdata_wdata, .code_rdata, .jtag_wdata, .jtag_rdata, .xdata_addr, .code_addr,
   .jtag_addr, .timing_prescale_field, .jtag_cmd);

// ===== core_partner.sv
`timescale 1ns/1ps
module core_partner (
   // clock
   input wire logic        clock,
   // core side of the guard
   output logic            xdata_move_op, code_read_op,
   output logic [15:0]     xdata_addr, code_addr,
   output logic [7:0]      xdata_wdata,
   input wire logic [7:0]  code_rdata,
   input wire logic        core_stall
);
   // idle at time zero
   initial begin
      xdata_move_op = 1'b0;
      code_read_op  = 1'b0;
      xdata_addr    = 16'h0000;
      code_addr     = 16'h0000;
      xdata_wdata   = 8'h00;
   end
   // one move write; the core waits out the stall before its next request
   task automatic move_write(input logic [15:0] a, input logic [7:0] d, output int len);
      len = 0;
      @(posedge clock); #1;
      xdata_move_op = 1'b1;
      xdata_addr    = a;
      xdata_wdata   = d;
      @(posedge clock); #1;
      xdata_move_op = 1'b0;
      xdata_addr    = ~a;
      xdata_wdata   = ~d;
      while (core_stall === 1'b1 && len < 2000) begin
         @(posedge clock); #1;
         len++;
      end
   endtask : move_write
   // one code read, data taken one cycle after the request
   task automatic code_read(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock); #1;
      code_read_op = 1'b1;
      code_addr    = a;
      @(posedge clock); #1;
      code_read_op = 1'b0;
      code_addr    = ~a;
      d = code_rdata;
   endtask : code_read
endmodule : core_partner

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module tb_top;
   localparam int EC = 600;
   localparam int WC = 4;
   // design ports
   logic                       clock = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic                       jtag_req = 1'b0;
   logic [7:0]                 sfr_addr = 8'h00, sfr_wdata = 8'h00, jtag_wdata = 8'h00;
   logic [3:0]                 timing_prescale_field = 4'h0;
   logic [15:0]                jtag_addr = 16'h0000;
   flash_guard_pkg::jtag_cmd_t jtag_cmd = flash_guard_pkg::JTAG_READ;
   logic                       xdata_move_op, code_read_op, core_stall, jtag_ack, jtag_refused;
   logic [15:0]                xdata_addr, code_addr;
   logic [7:0]                 xdata_wdata, sfr_rdata, code_rdata, jtag_rdata, rd;
   // bench model state
   int                         mismatches = 0, comparisons = 0, cycles = 0, n;
   logic [31:0]                seed = 32'h0000_0048;
   logic [7:0]                 mem [0:32895];
   logic [1:0]                 m_ctrl = 2'b00;
   logic [15:0]                written[$];
   always #2.5 clock = ~clock;
   flash_write_erase_guard #(.ERASE_CYCLES(EC), .WRITE_CYCLES(WC)) uut (.clock, .rst_n,
      .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .timing_prescale_field,
      .xdata_move_op, .xdata_addr, .xdata_wdata, .code_read_op, .code_addr, .code_rdata,
      .core_stall, .jtag_req, .jtag_cmd, .jtag_addr, .jtag_wdata, .jtag_rdata, .jtag_ack,
      .jtag_refused);
   core_partner core (.clock, .xdata_move_op, .xdata_addr, .xdata_wdata, .code_read_op,
      .code_addr, .code_rdata, .core_stall);
   // xorshift source
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   // model erase of the sector that holds a
   task automatic wipe(input logic [15:0] a);
      for (int i = 0; i < ((a >= 16'h8000) ? 128 : 512); i++)
         mem[((a >= 16'h8000) ? 16'h8000 : (a & 16'hfe00)) + i] = 8'hff;
   endtask : wipe
   // register write or read; read data is seen on return
   task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock); #1;
      sfr_wr = w; sfr_rd = !w; sfr_addr = a; sfr_wdata = d;
      @(posedge clock); #1;
      sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = ~a;
      if (w && a == 8'h8f) m_ctrl = d[1:0];
   endtask : sfr
   // core move write against the model, stall length compared
   task automatic core_wr(input logic [15:0] a, input logic [7:0] d);
      int len;
      len = 0;
      if (m_ctrl[0] && timing_prescale_field != 4'hf && a <= 16'h807f) begin
         if (!m_ctrl[1]) begin
            mem[a] = mem[a] & d;
            len = WC;
         end else if (a < 16'h7c00 || a > 16'h7dff) begin
            wipe(a);
            len = EC;
         end
      end
      core.move_write(a, d, n);
      `CHK("stall cycles", len, n)
      `CHK("stall after op", 1'b0, core_stall)
   endtask : core_wr
   task automatic check_rd(input logic [15:0] a);
      core.code_read(a, rd);
      `CHK("code byte", (a > 16'h807f) ? 8'h00 : mem[a], rd)
   endtask : check_rd
   // debug port command against the lock bytes of the model
   task automatic jt(input flash_guard_pkg::jtag_cmd_t c, input logic [15:0] a,
                     input logic [7:0] d);
      logic rd_c, refuse;
      rd_c = c == flash_guard_pkg::JTAG_READ;
      refuse = rd_c ? !mem[16'h7dff][a[14:12]] : !mem[16'h7dfe][a[14:12]];
      refuse = a > 16'h807f || (a < 16'h8000 && refuse) ||
               (!rd_c && timing_prescale_field == 4'hf);
      n = 0;
      @(posedge clock); #1;
      jtag_req = 1'b1; jtag_cmd = c; jtag_addr = a; jtag_wdata = d;
      @(posedge clock); #1;
      jtag_req = 1'b0; jtag_addr = ~a; jtag_wdata = ~d;
      while (jtag_ack !== 1'b1 && jtag_refused !== 1'b1 && n < 2000) begin
         @(posedge clock); #1;
         n++;
      end
      `CHK("debug refused", refuse, jtag_refused)
      `CHK("debug ack", !refuse, jtag_ack)
      `CHK("debug cycles", (refuse || rd_c) ? 0 : ((c == flash_guard_pkg::JTAG_WRITE) ? WC : EC), n)
      if (!refuse && rd_c) `CHK("debug data", mem[a], jtag_rdata)
      if (!refuse && c == flash_guard_pkg::JTAG_WRITE) mem[a] = mem[a] & d;
      if (!refuse && c == flash_guard_pkg::JTAG_ERASE) wipe(a);
   endtask : jt
   task automatic close_out();
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   // main sequence
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      repeat (8) @(posedge clock);
      #1 rst_n = 1'b1;
      sfr(1'b0, 8'h8f, 8'h00);
      `CHK("control reset", 8'h00, sfr_rdata)
      sfr(1'b0, 8'h8e, 8'h00);
      `CHK("unmapped read", 8'h00, sfr_rdata)
      core_wr(16'h0100, 8'h00);
      check_rd(16'h0100);
      sfr(1'b1, 8'h8f, 8'hfd);
      sfr(1'b0, 8'h8f, 8'h00);
      `CHK("control bits", 8'h01, sfr_rdata)
      for (int i = 0; i < 16; i++) begin
         written.push_back({rnd(), rnd()} & 16'h7bff);
         core_wr(written[i], rnd());
      end
      core_wr(written[0], rnd());
      core_wr(16'h8010, 8'h5a);
      core_wr(16'h7dfe, 8'hfe);
      core_wr(16'h7dff, 8'hfd);
      @(posedge clock); #1 timing_prescale_field = 4'hf;
      core_wr(16'h0300, 8'h00);
      jt(flash_guard_pkg::JTAG_WRITE, 16'h1010, 8'h00);
      @(posedge clock); #1 timing_prescale_field = 4'h0;
      sfr(1'b1, 8'h8f, 8'h02);
      core_wr(16'h0400, 8'h00);
      sfr(1'b1, 8'h8f, 8'h03);
      core_wr(16'h7d00, 8'h00);
      core_wr(16'h8000, 8'h00);
      core_wr(written[0], 8'h00);
      sfr(1'b1, 8'h8f, 8'h00);
      foreach (written[i]) check_rd(written[i]);
      foreach (written[i]) check_rd(written[i] | 16'h01ff);
      check_rd(16'h8010);
      check_rd(16'h7dfe);
      check_rd(16'h9000);
      jt(flash_guard_pkg::JTAG_WRITE, 16'h0010, 8'h00);
      jt(flash_guard_pkg::JTAG_WRITE, 16'h1010, 8'h3c);
      jt(flash_guard_pkg::JTAG_ERASE, 16'h0200, 8'h00);
      jt(flash_guard_pkg::JTAG_READ, 16'h1010, 8'h00);
      jt(flash_guard_pkg::JTAG_READ, 16'h2010, 8'h00);
      jt(flash_guard_pkg::JTAG_READ, 16'h0010, 8'h00);
      jt(flash_guard_pkg::JTAG_READ, 16'h8010, 8'h00);
      jt(flash_guard_pkg::JTAG_ERASE, 16'h1000, 8'h00);
      check_rd(16'h1010);
      sfr(1'b1, 8'h8f, 8'hff);
      sfr(1'b0, 8'h8f, 8'h00);
      `CHK("control unused bits", 8'h03, sfr_rdata)
      close_out();
   end
endmodule : tb_top
